/* verilog/lcd_drive_control.sv */
// display drive control: reset state, drive mode, bias, clock source and display memory
`timescale 1ns/1ps
`include "lcd_drive_params.svh"

module lcd_drive_control (
	input  wire logic                               CLK_SYS,
	input  wire logic                               RST,
	input  wire logic                               OSC_SELECT,
	input  wire logic                               CLK_IN,
	output logic                                    CLK_OUT,
	output logic                                    CLK_OE,
	input  wire logic [`SUBADDR_W-1:0]              HW_SUBADDR,
	input  wire logic                               MODE_SET,
	input  wire lcd_drive_pkg::drive_mode_type      MODE_DRIVE,
	input  wire logic                               MODE_HALF_BIAS,
	input  wire logic                               MODE_POWER_SAVE,
	input  wire logic                               MODE_DISPLAY_ON,
	input  wire logic                               BLINK_SET,
	input  wire logic [1:0]                         BLINK_FREQ,
	input  wire logic                               BANK_SET,
	input  wire logic                               BANK_INPUT,
	input  wire logic                               BANK_OUTPUT,
	input  wire logic                               LOAD_POINTER,
	input  wire logic [`PTR_W-1:0]                  POINTER_VALUE,
	input  wire logic                               DEVICE_SELECT,
	input  wire logic [`SUBADDR_W-1:0]              SUBADDR_VALUE,
	input  wire logic                               DATA_VALID,
	input  wire logic [7:0]                         DATA_BYTE,
	output logic                                    DATA_READY,
	output logic                                    SCL_OUT,
	output logic                                    SCL_OE,
	output logic [`NUM_BACKPLANES-1:0][1:0]         BACKPLANE_DRIVE_OUTPUTS,
	output logic [`NUM_SEGMENTS-1:0][1:0]           SEGMENT_DRIVE_OUTPUTS
);

	typedef struct packed {
		logic                                   osc_sel_s1;
		logic                                   osc_sel_s2;
		logic                                   clk_s1;
		logic                                   clk_s2;
		logic                                   clk_s3;
		logic [`SUBADDR_W-1:0]                  hw_s1;
		logic [`SUBADDR_W-1:0]                  hw_s2;
		logic [`OSC_CNT_W-1:0]                  osc_cnt;
		logic                                   osc_level;
		lcd_drive_pkg::drive_mode_type          mode;
		logic                                   half_bias;
		logic                                   power_save;
		logic                                   display_on;
		logic [1:0]                             blink;
		logic                                   bank_in;
		logic                                   bank_out;
		logic [`PTR_W-1:0]                      ptr;
		logic [`SUBADDR_W-1:0]                  subaddr;
		lcd_drive_pkg::store_state_type         store;
		logic [7:0]                             byte_buf;
		logic [`NUM_SEGMENTS-1:0][3:0]          ram;
		logic [`BLINK_CNT_W-1:0]                blink_cnt;
		logic [`NUM_BACKPLANES-1:0][1:0]        bp_out;
		logic [`NUM_SEGMENTS-1:0][1:0]          seg_out;
		logic                                   clk_oe;
		logic                                   scl_oe;
		logic                                   data_ready;
	} ctrl_state_type;

	ctrl_state_type state;
	ctrl_state_type next_state;

	logic       f_clk_tick;
	logic [1:0] slot;
	logic       polarity;
	logic       frame_end;

	function automatic logic [`PTR_W-1:0] ptr_step(input lcd_drive_pkg::drive_mode_type m);
		case (m)
			lcd_drive_pkg::MODE_STATIC:  ptr_step = `STEP_STATIC;
			lcd_drive_pkg::MODE_DUPLEX:  ptr_step = `STEP_DUPLEX;
			lcd_drive_pkg::MODE_TRIPLEX: ptr_step = `STEP_TRIPLEX;
			default:                     ptr_step = `STEP_QUAD;
		endcase
	endfunction : ptr_step

	// bits per memory word for the mode: 1, 2, 3 or 4
	function automatic logic [2:0] bits_per_word(input lcd_drive_pkg::drive_mode_type m);
		case (m)
			lcd_drive_pkg::MODE_STATIC:  bits_per_word = 3'h1;
			lcd_drive_pkg::MODE_DUPLEX:  bits_per_word = 3'h2;
			lcd_drive_pkg::MODE_TRIPLEX: bits_per_word = 3'h3;
			default:                     bits_per_word = 3'h4;
		endcase
	endfunction : bits_per_word

	// bank offset applies only in static and duplex modes
	function automatic logic [1:0] bank_row(input logic [1:0] row, input logic bank,
		input lcd_drive_pkg::drive_mode_type m);
		if (bank && (m == lcd_drive_pkg::MODE_STATIC || m == lcd_drive_pkg::MODE_DUPLEX)) begin
			bank_row = row + `BANK_ROW_OFFSET;
		end else begin
			bank_row = row;
		end
	endfunction : bank_row

	// physical backplane to the active backplane whose signal it carries
	function automatic logic [1:0] bp_source(input logic [1:0] bp,
		input lcd_drive_pkg::drive_mode_type m);
		case (m)
			lcd_drive_pkg::MODE_STATIC:  bp_source = 2'h0;
			lcd_drive_pkg::MODE_DUPLEX:  bp_source = {1'b0, bp[0]};
			lcd_drive_pkg::MODE_TRIPLEX: bp_source = (bp == 2'h3) ? 2'h1 : bp;
			default:                     bp_source = bp;
		endcase
	endfunction : bp_source

	function automatic logic [1:0] bp_level(input logic sel, input logic pol,
		input logic half, input logic stat);
		if (sel || stat) begin
			bp_level = pol ? `LVL_VLCD : `LVL_VDD;
		end else if (half) begin
			bp_level = `LVL_HI;
		end else begin
			bp_level = pol ? `LVL_HI : `LVL_LO;
		end
	endfunction : bp_level

	function automatic logic [1:0] seg_level(input logic on, input logic pol,
		input logic half, input logic stat);
		if (on) begin
			seg_level = pol ? `LVL_VDD : `LVL_VLCD;
		end else if (half || stat) begin
			seg_level = pol ? `LVL_VLCD : `LVL_VDD;
		end else begin
			seg_level = pol ? `LVL_LO : `LVL_HI;
		end
	endfunction : seg_level

	lcd_frame_divider frame_divider (
		.clk        (CLK_SYS),
		.rst        (RST),
		.tick       (f_clk_tick),
		.power_save (state.power_save),
		.mode       (state.mode),
		.slot       (slot),
		.polarity   (polarity),
		.frame_end  (frame_end)
	);

	// one f_clk source at a time; the external pin only counts when selected
	assign f_clk_tick = state.osc_sel_s2 ? (state.clk_s2 & ~state.clk_s3)
		: (state.osc_cnt == `OSC_CNT_W'(`OSC_HALF_CYCLES - 1) && !state.osc_level);

	always_comb begin
		logic [`PTR_W:0]  ptr_sum;
		logic [`PTR_W:0]  word;
		logic [2:0]       bpw;
		logic [1:0]       row;
		logic [1:0]       src;
		logic             blank;
		logic             stat;
		next_state = state;
		ptr_sum = '0;
		word = '0;
		bpw = '0;
		row = '0;
		src = '0;
		blank = 1'b0;
		stat = 1'b0;

		next_state.osc_sel_s1 = OSC_SELECT;
		next_state.osc_sel_s2 = state.osc_sel_s1;
		next_state.clk_s1 = CLK_IN;
		next_state.clk_s2 = state.clk_s1;
		next_state.clk_s3 = state.clk_s2;
		next_state.hw_s1 = HW_SUBADDR;
		next_state.hw_s2 = state.hw_s1;

		if (state.osc_sel_s2) begin
			next_state.osc_cnt = '0;
			next_state.osc_level = 1'b0;
			next_state.clk_oe = 1'b0;
		end else begin
			next_state.clk_oe = 1'b1;
			if (state.osc_cnt == `OSC_CNT_W'(`OSC_HALF_CYCLES - 1)) begin
				next_state.osc_cnt = '0;
				next_state.osc_level = ~state.osc_level;
			end else begin
				next_state.osc_cnt = state.osc_cnt + `OSC_CNT_W'(1);
			end
		end

		if (MODE_SET) begin
			next_state.mode = MODE_DRIVE;
			next_state.half_bias = MODE_HALF_BIAS;
			next_state.power_save = MODE_POWER_SAVE;
			next_state.display_on = MODE_DISPLAY_ON;
		end
		if (BLINK_SET) begin
			next_state.blink = BLINK_FREQ;
		end
		if (BANK_SET) begin
			next_state.bank_in = BANK_INPUT;
			next_state.bank_out = BANK_OUTPUT;
		end
		if (DEVICE_SELECT) begin
			next_state.subaddr = SUBADDR_VALUE;
		end
		if (LOAD_POINTER) begin
			next_state.ptr = POINTER_VALUE;
		end
		if (frame_end) begin
			next_state.blink_cnt = state.blink_cnt + `BLINK_CNT_W'(1);
		end

		// storage waits for an f_clk tick, so a slow f_clk can stall the bus
		case (state.store)
			lcd_drive_pkg::ST_IDLE: begin
				if (DATA_VALID) begin
					next_state.byte_buf = DATA_BYTE;
					next_state.store = lcd_drive_pkg::ST_STORE;
				end
			end
			lcd_drive_pkg::ST_STORE: begin
				if (f_clk_tick) begin
					bpw = bits_per_word(state.mode);
					if (state.subaddr == state.hw_s2) begin
						for (int k = 0; k < 8; k++) begin
							word = {1'b0, state.ptr} + (`PTR_W+1)'(k / int'(bpw));
							row = bank_row(2'(k % int'(bpw)), state.bank_in, state.mode);
							if (word < (`PTR_W+1)'(`NUM_SEGMENTS)) begin
								next_state.ram[word[`PTR_W-1:0]][row] = state.byte_buf[7-k];
							end
						end
					end
					ptr_sum = {1'b0, state.ptr} + {1'b0, ptr_step(state.mode)};
					if (ptr_sum >= (`PTR_W+1)'(`NUM_SEGMENTS)) begin
						ptr_sum = ptr_sum - (`PTR_W+1)'(`NUM_SEGMENTS);
						next_state.subaddr = state.subaddr + `SUBADDR_W'(1);
					end
					if (!LOAD_POINTER) begin
						next_state.ptr = ptr_sum[`PTR_W-1:0];
					end
					next_state.store = lcd_drive_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state.store = lcd_drive_pkg::ST_IDLE;
			end
		endcase
		next_state.data_ready = (next_state.store == lcd_drive_pkg::ST_IDLE);
		// a second byte while the first is unstored stretches the clock low
		next_state.scl_oe = DATA_VALID && (next_state.store == lcd_drive_pkg::ST_STORE)
			&& (state.store == lcd_drive_pkg::ST_STORE);

		case (state.blink)
			2'h1:    blank = state.blink_cnt[`BLINK_BIT_SLOW];
			2'h2:    blank = state.blink_cnt[`BLINK_BIT_MID];
			2'h3:    blank = state.blink_cnt[`BLINK_BIT_FAST];
			default: blank = 1'b0;
		endcase

		stat = (state.mode == lcd_drive_pkg::MODE_STATIC);
		for (int b = 0; b < `NUM_BACKPLANES; b++) begin
			src = bp_source(2'(b), state.mode);
			next_state.bp_out[b] = state.display_on
				? bp_level(src == slot, polarity, state.half_bias, stat) : `LVL_VDD;
		end
		row = bank_row(slot, state.bank_out, state.mode);
		for (int s = 0; s < `NUM_SEGMENTS; s++) begin
			next_state.seg_out[s] = state.display_on
				? seg_level(state.ram[s][row] && !blank, polarity, state.half_bias, stat)
				: `LVL_VDD;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			state <= '0;
			state.mode <= lcd_drive_pkg::MODE_QUAD;
			state.half_bias <= 1'b0;
			state.store <= lcd_drive_pkg::ST_IDLE;
			state.data_ready <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	assign CLK_OUT = state.osc_level;
	assign CLK_OE = state.clk_oe;
	assign DATA_READY = state.data_ready;
	assign SCL_OUT = 1'b0;
	assign SCL_OE = state.scl_oe;
	assign BACKPLANE_DRIVE_OUTPUTS = state.bp_out;
	assign SEGMENT_DRIVE_OUTPUTS = state.seg_out;

endmodule : lcd_drive_control

/* verilog/lcd_drive_params.svh */
// constants for the display drive, clock and reset control block
`ifndef LCD_DRIVE_PARAMS_SVH
`define LCD_DRIVE_PARAMS_SVH

`define SYS_FREQ_KHZ        40000
`define OSC_FREQ_KHZ        200
`define OSC_HALF_CYCLES     (`SYS_FREQ_KHZ / (2 * `OSC_FREQ_KHZ))
`define OSC_CNT_W           8

`define DIV_NORMAL          2880
`define DIV_POWER_SAVE      480
`define SLOT_CNT_W          12

`define NUM_SEGMENTS        40
`define NUM_BACKPLANES      4
`define PTR_W               6
`define SUBADDR_W           3

`define STEP_STATIC         6'h08
`define STEP_DUPLEX         6'h04
`define STEP_TRIPLEX        6'h03
`define STEP_QUAD           6'h02

`define LVL_VDD             2'h0
`define LVL_HI              2'h1
`define LVL_LO              2'h2
`define LVL_VLCD            2'h3

`define BANK_ROW_OFFSET     2'h2
`define BLINK_CNT_W         8
`define BLINK_BIT_SLOW      7
`define BLINK_BIT_MID       6
`define BLINK_BIT_FAST      5

`endif

/* verilog/lcd_drive_pkg.sv */
// types shared by the display drive control modules
package lcd_drive_pkg;

	typedef enum logic [1:0] {
		MODE_QUAD    = 2'h0,
		MODE_STATIC  = 2'h1,
		MODE_DUPLEX  = 2'h2,
		MODE_TRIPLEX = 2'h3
	} drive_mode_type;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'h1,
		ST_STORE = 2'h2
	} store_state_type;

endpackage : lcd_drive_pkg

/* verilog/lcd_frame_divider.sv */
// frame timing: divides f_clk ticks into backplane slots and alternating-polarity frames
`timescale 1ns/1ps
`include "lcd_drive_params.svh"

module lcd_frame_divider (
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire logic                          tick,
	input  wire logic                          power_save,
	input  wire lcd_drive_pkg::drive_mode_type mode,
	output logic      [1:0]                    slot,
	output logic                               polarity,
	output logic                               frame_end
);

	typedef struct packed {
		logic [`SLOT_CNT_W-1:0] cnt;
		logic [1:0]             slot;
		logic                   polarity;
		logic                   frame_end;
	} div_state_type;

	div_state_type state;
	div_state_type next_state;

	function automatic logic [1:0] last_slot(input lcd_drive_pkg::drive_mode_type m);
		case (m)
			lcd_drive_pkg::MODE_STATIC:  last_slot = 2'h0;
			lcd_drive_pkg::MODE_DUPLEX:  last_slot = 2'h1;
			lcd_drive_pkg::MODE_TRIPLEX: last_slot = 2'h2;
			default:                     last_slot = 2'h3;
		endcase
	endfunction : last_slot

	// slot length times active backplanes equals the frame divisor
	function automatic logic [`SLOT_CNT_W-1:0] slot_len(input logic ps,
		input lcd_drive_pkg::drive_mode_type m);
		logic [`SLOT_CNT_W-1:0] div;
		div = ps ? `SLOT_CNT_W'(`DIV_POWER_SAVE) : `SLOT_CNT_W'(`DIV_NORMAL);
		case (m)
			lcd_drive_pkg::MODE_STATIC:  slot_len = div;
			lcd_drive_pkg::MODE_DUPLEX:  slot_len = div / `SLOT_CNT_W'(2);
			lcd_drive_pkg::MODE_TRIPLEX: slot_len = div / `SLOT_CNT_W'(3);
			default:                     slot_len = div / `SLOT_CNT_W'(4);
		endcase
	endfunction : slot_len

	always_comb begin
		next_state = state;
		next_state.frame_end = 1'b0;
		if (tick) begin
			if (state.cnt >= slot_len(power_save, mode) - `SLOT_CNT_W'(1)) begin
				next_state.cnt = '0;
				if (state.slot >= last_slot(mode)) begin
					next_state.slot = 2'h0;
					next_state.polarity = ~state.polarity;
					next_state.frame_end = 1'b1;
				end else begin
					next_state.slot = state.slot + 2'h1;
				end
			end else begin
				next_state.cnt = state.cnt + `SLOT_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign slot = state.slot;
	assign polarity = state.polarity;
	assign frame_end = state.frame_end;

endmodule : lcd_frame_divider

/* verification/lcd_drive_control_sva.sv */
// port assertions for the display drive control block
`timescale 1ns/1ps
`include "lcd_drive_params.svh"

module lcd_drive_control_sva (
	input  wire logic                                 CLK_SYS,
	input  wire logic                                 RST,
	input  wire logic                                 OSC_SELECT,
	input  wire logic                                 CLK_OUT,
	input  wire logic                                 CLK_OE,
	input  wire logic                                 MODE_SET,
	input  wire lcd_drive_pkg::drive_mode_type        MODE_DRIVE,
	input  wire logic                                 DATA_VALID,
	input  wire logic                                 DATA_READY,
	input  wire logic                                 SCL_OUT,
	input  wire logic                                 SCL_OE,
	input  wire logic [`NUM_BACKPLANES-1:0][1:0]      BACKPLANE_DRIVE_OUTPUTS,
	input  wire logic [`NUM_SEGMENTS-1:0][1:0]        SEGMENT_DRIVE_OUTPUTS
);
	default clocking cb @(posedge CLK_SYS); endclocking

	lcd_drive_pkg::drive_mode_type seen_mode;
	logic [2:0]                    settle;
	wire logic [3:0][1:0]          bp = BACKPLANE_DRIVE_OUTPUTS;

	// mode takes two cycles to reach the pins; two more for margin
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			seen_mode <= lcd_drive_pkg::MODE_QUAD;
			settle    <= 3'h0;
		end else if (MODE_SET) begin
			seen_mode <= MODE_DRIVE;
			settle    <= 3'h0;
		end else if (settle != 3'h7) begin
			settle <= settle + 3'h1;
		end
	end

	a_reset_quiet: assert property (RST |=> bp == '0 && SEGMENT_DRIVE_OUTPUTS == '0)
		else $error("drive outputs not at supply after reset");
	a_reset_bus_idle: assert property (RST |=> DATA_READY && !SCL_OE && !CLK_OE)
		else $error("bus side not idle after reset");
	a_int_osc_out: assert property (disable iff (RST) (!OSC_SELECT)[*8] |-> CLK_OE)
		else $error("internal clock not driven out");
	a_ext_osc_off: assert property (disable iff (RST) OSC_SELECT[*8] |-> !CLK_OE && !CLK_OUT)
		else $error("oscillator still driving in external mode");
	a_osc_runs: assert property (disable iff (RST) (!OSC_SELECT)[*8] |->
		##[0:101] ($changed(CLK_OUT) || OSC_SELECT))
		else $error("internal oscillator stalled");
	a_take_drops_ready: assert property (disable iff (RST) DATA_VALID && DATA_READY |=> !DATA_READY)
		else $error("byte taken but still ready");
	a_store_bounded: assert property (disable iff (RST) $fell(DATA_READY) |-> ##[1:300] DATA_READY)
		else $error("store never finished");
	a_hold_scl: assert property (disable iff (RST) (DATA_VALID && !DATA_READY)[*3] |-> SCL_OE)
		else $error("serial clock not held while busy");
	a_scl_low_only: assert property (disable iff (RST) SCL_OUT == 1'b0)
		else $error("serial clock driven high");
	a_spare_copies: assert property (disable iff (RST) settle >= 3'h3 |->
		(seen_mode != lcd_drive_pkg::MODE_STATIC || (bp[1] == bp[0] && bp[2] == bp[0] && bp[3] == bp[0]))
		&& (seen_mode != lcd_drive_pkg::MODE_DUPLEX || (bp[2] == bp[0] && bp[3] == bp[1]))
		&& (seen_mode != lcd_drive_pkg::MODE_TRIPLEX || bp[3] == bp[1]))
		else $error("spare backplane does not copy");

	c_scl_hold: cover property (disable iff (RST) SCL_OE);
	c_static: cover property (disable iff (RST) seen_mode == lcd_drive_pkg::MODE_STATIC && settle == 3'h7);
	c_ext_store: cover property (disable iff (RST) OSC_SELECT && $rose(DATA_READY));
endmodule : lcd_drive_control_sva

bind lcd_drive_control lcd_drive_control_sva u_sva (.CLK_SYS(CLK_SYS), .RST(RST),
	.OSC_SELECT(OSC_SELECT), .CLK_OUT(CLK_OUT), .CLK_OE(CLK_OE), .MODE_SET(MODE_SET),
	.MODE_DRIVE(MODE_DRIVE), .DATA_VALID(DATA_VALID), .DATA_READY(DATA_READY),
	.SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .BACKPLANE_DRIVE_OUTPUTS(BACKPLANE_DRIVE_OUTPUTS),
	.SEGMENT_DRIVE_OUTPUTS(SEGMENT_DRIVE_OUTPUTS));

/* verification/ext_clock_source.sv */
// external clock source feeding the shared clock pin
`timescale 1ns/1ps

module ext_clock_source #(
	parameter real HALF = 100.0
) (
	input  wire logic run,
	output logic      clk_pin
);
	// once started it never stops, so the display never freezes
	initial begin
		clk_pin = 1'b0;
		wait (run === 1'b1);
		#37;
		forever begin
			#(HALF) clk_pin = ~clk_pin; // 5 MHz, far above 125 kHz
		end
	end
endmodule : ext_clock_source

/* verification/lcd_drive_control_bench.sv */
// self-checking bench for the display drive control block
`timescale 1ns/1ps
`include "lcd_drive_params.svh"

module lcd_drive_control_bench;
	localparam int TICK_CYCLES = 8;
	localparam int POR_WAIT_CYCLES = 40000;
	logic                          clk_sys, rst, osc_sel, mode_set, half, psave, disp_on;
	logic                          blink_set, bank_set, ld_ptr, dev_sel, valid, scl_seen, s2;
	logic                          clk_out, clk_oe, ready, scl_out, scl_oe, ext_clk;
	logic [2:0]                    hw_sub;
	logic [7:0]                    byte_in, a, b;
	logic [1:0]                    p;
	logic [15:0][1:0]              es;
	logic [3:0][1:0]               bp, prev;
	logic [39:0][1:0]              seg;
	lcd_drive_pkg::drive_mode_type mode;
	lcd_drive_pkg::drive_mode_type mt [4];
	logic [95:0]                   exp_q[$];
	logic [95:0]                   got_q[$];
	int                            num_errors, compares, n, chg;
	event                          look;
	wire logic                     clk_pin = clk_oe ? clk_out : ext_clk;

	lcd_drive_control u_dut (.CLK_SYS(clk_sys), .RST(rst), .OSC_SELECT(osc_sel),
		.CLK_IN(clk_pin), .CLK_OUT(clk_out), .CLK_OE(clk_oe), .HW_SUBADDR(hw_sub),
		.MODE_SET(mode_set), .MODE_DRIVE(mode), .MODE_HALF_BIAS(half),
		.MODE_POWER_SAVE(psave), .MODE_DISPLAY_ON(disp_on), .BLINK_SET(blink_set),
		.BLINK_FREQ(2'h0), .BANK_SET(bank_set), .BANK_INPUT(1'b0), .BANK_OUTPUT(1'b0),
		.LOAD_POINTER(ld_ptr), .POINTER_VALUE(6'h00), .DEVICE_SELECT(dev_sel),
		.SUBADDR_VALUE(hw_sub), .DATA_VALID(valid), .DATA_BYTE(byte_in), .DATA_READY(ready),
		.SCL_OUT(scl_out), .SCL_OE(scl_oe), .BACKPLANE_DRIVE_OUTPUTS(bp),
		.SEGMENT_DRIVE_OUTPUTS(seg));

	ext_clock_source u_src (.run(osc_sel), .clk_pin(ext_clk));

	task check(input logic [95:0] got, input logic [95:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task note(input logic [95:0] got, input logic [95:0] exp);
		got_q.push_back(got);
		exp_q.push_back(exp);
		-> look;
	endtask : note

	task report_and_stop;
		if (num_errors == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : report_and_stop

	task set_mode(input lcd_drive_pkg::drive_mode_type m, input logic h);
		mode = m;
		half = h;
		mode_set = 1'b1;
		@(negedge clk_sys);
		mode_set = 1'b0;
	endtask : set_mode

	// counts falling edges until the watched output moves
	task wait_change(input bit on_clk, output int cnt);
		logic [7:0] ref_val;
		ref_val = on_clk ? {7'h00, clk_out} : bp;
		cnt = 0;
		while ((on_clk ? {7'h00, clk_out} : bp) === ref_val && cnt < 9000) begin
			@(negedge clk_sys);
			cnt++;
		end
	endtask : wait_change

	// valid is left high on return so back-to-back bytes overlap a busy store
	task send_byte(input logic [7:0] v);
		valid = 1'b1;
		byte_in = v;
		n = 0;
		while (ready !== 1'b1 && n < 400) begin
			if (scl_oe === 1'b1) scl_seen = 1'b1;
			@(negedge clk_sys);
			n++;
		end
		@(negedge clk_sys);
	endtask : send_byte

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	initial forever begin
		@(look);
		while (exp_q.size() > 0) check(got_q.pop_front(), exp_q.pop_front());
	end

	initial begin
		#2450000;
		num_errors++;
		report_and_stop();
	end

	initial begin
		rst = 1'b1;
		{osc_sel, half, psave, disp_on, valid, scl_seen, mode_set} = 7'h00;
		{blink_set, bank_set, ld_ptr, dev_sel} = 4'h0;
		mode = lcd_drive_pkg::MODE_QUAD;
		mt = '{lcd_drive_pkg::MODE_STATIC, lcd_drive_pkg::MODE_DUPLEX,
			lcd_drive_pkg::MODE_TRIPLEX, lcd_drive_pkg::MODE_QUAD};
		byte_in = 8'h00;
		hw_sub = 3'($urandom(32'h2671ab32));
		repeat (3) @(negedge clk_sys);
		note({ready, scl_oe, clk_oe, bp, seg}, {3'h4, 88'h0});
		rst = 1'b0;
		// blink and banks stay at their reset values, so the data check sees them
		repeat (11) @(negedge clk_sys);
		note(clk_oe, 1'b1);
		wait_change(1'b1, n);
		wait_change(1'b1, n);
		note(n, `OSC_HALF_CYCLES);
		osc_sel = 1'b1;
		repeat (10) @(negedge clk_sys);
		note({clk_oe, clk_out}, 2'h0);
		// no command or data until a full 1 ms after power-on
		repeat (POR_WAIT_CYCLES) @(negedge clk_sys);
		psave = 1'b1;
		disp_on = 1'b1;
		set_mode(lcd_drive_pkg::MODE_STATIC, 1'b0);
		{ld_ptr, dev_sel} = 2'h3;
		@(negedge clk_sys);
		{ld_ptr, dev_sel} = 2'h0;
		a = 8'($urandom());
		b = 8'($urandom());
		send_byte(a);
		send_byte(b);
		valid = 1'b0;
		note(scl_seen, 1'b1);
		wait_change(1'b0, n);
		repeat (100) @(negedge clk_sys);
		p = (bp[0] === 2'h3) ? 2'h3 : 2'h0;
		for (int i = 0; i < 16; i++) es[i] = (i < 8 ? a[7 - i] : b[15 - i]) ? ~p : p;
		note({bp, seg[15:0]}, {{4{p}}, es});
		wait_change(1'b0, n);
		note(bp, {4{~p}});
		wait_change(1'b0, n);
		note(n, `DIV_POWER_SAVE * TICK_CYCLES);
		for (int k = 0; k < 4; k++) begin
			set_mode(mt[k], k > 0 ? 1'($urandom()) : 1'b0);
			// first slot edge after the switch restarts the slot count cleanly
			repeat (3) @(negedge clk_sys);
			wait_change(1'b0, n);
			chg = 0;
			s2 = 1'b0;
			prev = bp;
			repeat (7676) begin
				@(negedge clk_sys);
				if (bp !== prev) chg++;
				for (int j = 0; j < 4; j++) if (bp[j] === 2'h2) s2 = 1'b1;
				prev = bp;
			end
			note(chg, 2 * (k + 1) - 1);
			note(s2, k > 0 && !half);
		end
		@(negedge clk_sys);
		report_and_stop();
	end
endmodule : lcd_drive_control_bench
